// ---- design/flash_erase_block_control.sv ----
// Purpose: flash program/erase control, status and erase block select registers on APB.
// Assumes: synchronous inputs; standby arrives as a request level.
// Notes: reads answer with pready in the access cycle, no wait states.
// Function
// - Error flag, status bit 7, sets on error protection entry.
// - Status bits 6 to 0 always read zero.
// - Low erase select forced zero while write protect is high.
// - Low erase select forced zero while software write enable is zero.
// - Several bits set across both erase selects clears both registers.
// - Low select bit n erases 4 KB block at n times 0x1000.
// - Control, error flag and erase selects cleared by reset and standby; interrupt status and mask by reset only.
// - In user mode write protect may toggle at any time.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "flash_erase_map.svh"
module flash_erase_block_control #(
  parameter int HIGH_BITS = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input flash_erase_pkg::apb_req_s apb_req,
  output flash_erase_pkg::apb_rsp_s apb_rsp,
  input wire logic flash_write_protect_input,
  input wire logic error_protect_event,
  input wire logic standby_req,
  output logic [7:0] control_bits,
  output logic [7:0] erase_block_select_low,
  output logic [HIGH_BITS-1:0] erase_block_select_high,
  output flash_erase_pkg::erase_range_s erase_range,
  output logic irq
);
  import flash_erase_pkg::*;

  // Block addresses must stay inside the 24-bit range field
  if (HIGH_BITS < 1 || HIGH_BITS > 24) begin : g_bad_high_bits
    $error("HIGH_BITS out of range");
  end

  localparam int NSEL = 8 + HIGH_BITS;

  logic [7:0] flash_control_r;
  logic [7:0] flash_control_nxt;
  logic flash_error_flag_r;
  logic [7:0] ebs_low_r;
  logic [7:0] ebs_low_nxt;
  logic [HIGH_BITS-1:0] ebs_high_r;
  logic [HIGH_BITS-1:0] ebs_high_nxt;
  logic [`IRQ_W-1:0] irq_status_r;
  logic [`IRQ_W-1:0] irq_status_nxt;
  logic [`IRQ_W-1:0] irq_mask_r;
  logic wp_prev_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  erase_range_s range_r;

  function automatic logic multi_bits(input logic [NSEL-1:0] v);
    return (v & (v - 1'b1)) != '0;
  endfunction

  wire logic setup_phase;
  wire logic wr_en;
  wire logic rd_en;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic hit_low;
  wire logic hit_high;
  wire logic hit_isr;
  wire logic hit_mask;
  wire logic hit_any;
  wire logic software_write_enable;
  wire logic clr_selects;
  wire logic autoclr;
  wire logic wp_change;
  wire logic [NSEL-1:0] sel_written;
  wire logic [7:0] low_written;
  wire logic [HIGH_BITS-1:0] high_written;
  wire logic [7:0] status_byte;
  wire logic [31:0] rd_word;
  wire logic [`IRQ_W-1:0] events;
  wire logic isr_read;
  erase_range_s range_w;

  // One cycle setup; answer is presented during the access phase
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign wr_en = setup_phase && apb_req.pwrite;
  assign rd_en = setup_phase && !apb_req.pwrite;

  assign hit_ctrl = apb_req.paddr == `OFS_FLASH_CONTROL;
  assign hit_stat = apb_req.paddr == `OFS_FLASH_STATUS;
  assign hit_low = apb_req.paddr == `OFS_EBS_LOW;
  assign hit_high = apb_req.paddr == `OFS_EBS_HIGH;
  assign hit_isr = apb_req.paddr == `OFS_IRQ_STATUS;
  assign hit_mask = apb_req.paddr == `OFS_IRQ_MASK;
  assign hit_any = hit_ctrl || hit_stat || hit_low || hit_high || hit_isr || hit_mask;

  assign software_write_enable = flash_control_r[`BIT_SWE];

  assign status_byte = {flash_error_flag_r, 7'h00};

  wire logic [31:0] rd_ctrl;
  wire logic [31:0] rd_stat;
  wire logic [31:0] rd_low;
  wire logic [31:0] rd_high;
  wire logic [31:0] rd_isr;
  wire logic [31:0] rd_mask;
  assign rd_ctrl = {24'h00_0000, flash_control_r};
  assign rd_stat = {24'h00_0000, status_byte};
  assign rd_low = {24'h00_0000, ebs_low_r};
  assign rd_high = 32'(ebs_high_r);
  assign rd_isr = 32'(irq_status_r);
  assign rd_mask = 32'(irq_mask_r);

  assign rd_word = hit_ctrl ? rd_ctrl :
                   hit_stat ? rd_stat :
                   hit_low ? rd_low :
                   hit_high ? rd_high :
                   hit_isr ? rd_isr :
                   hit_mask ? rd_mask : `RST_WORD;

  // Erase selections candidate after this cycle's write
  assign low_written = (wr_en && hit_low) ? apb_req.pwdata[7:0] : ebs_low_r;
  assign high_written = (wr_en && hit_high) ? apb_req.pwdata[HIGH_BITS-1:0] : ebs_high_r;
  assign sel_written = {high_written, low_written};

  assign autoclr = multi_bits(sel_written);
  assign clr_selects = flash_write_protect_input || !software_write_enable;

  assign wp_change = flash_write_protect_input != wp_prev_r;
  assign events[`IRQ_ERROR] = error_protect_event && !flash_error_flag_r;
  assign events[`IRQ_AUTOCLR] = autoclr && !clr_selects;
  assign events[`IRQ_WPCHG] = wp_change;
  assign isr_read = rd_en && hit_isr;

  always_comb begin
    flash_control_nxt = flash_control_r;
    if (wr_en && hit_ctrl) begin
      flash_control_nxt = apb_req.pwdata[7:0];
    end
    ebs_low_nxt = low_written;
    ebs_high_nxt = high_written;
    if (autoclr) begin
      ebs_low_nxt = `RST_BYTE;
      ebs_high_nxt = '0;
    end
    if (clr_selects) begin
      ebs_low_nxt = `RST_BYTE;
    end
    // Set wins over the clear on read
    irq_status_nxt = (isr_read ? '0 : irq_status_r) | events;
  end

  erase_range_decode #(
    .NBITS(NSEL)
  ) u_decode (
    .sel({ebs_high_r, ebs_low_r}),
    .range(range_w)
  );

  always_ff @(posedge mclk) begin
    if (reset || standby_req) begin
      flash_control_r <= `RST_BYTE;
      flash_error_flag_r <= 1'b0;
      ebs_low_r <= `RST_BYTE;
      ebs_high_r <= '0;
    end else begin
      flash_control_r <= flash_control_nxt;
      ebs_low_r <= ebs_low_nxt;
      ebs_high_r <= ebs_high_nxt;
      if (error_protect_event) begin
        flash_error_flag_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status_r <= '0;
      irq_mask_r <= '0;
      wp_prev_r <= 1'b1;
      irq_r <= 1'b0;
      range_r <= '0;
    end else begin
      irq_status_r <= irq_status_nxt;
      if (wr_en && hit_mask) begin
        irq_mask_r <= apb_req.pwdata[`IRQ_W-1:0];
      end
      wp_prev_r <= flash_write_protect_input;
      irq_r <= |(irq_status_nxt & irq_mask_r);
      range_r <= range_w;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_r <= `RST_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_phase;
      pslverr_r <= setup_phase && !hit_any;
      prdata_r <= rd_en ? rd_word : `RST_WORD;
    end
  end

  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pready = pready_r;
  assign apb_rsp.pslverr = pslverr_r;
  assign control_bits = flash_control_r;
  assign erase_block_select_low = ebs_low_r;
  assign erase_block_select_high = ebs_high_r;
  assign erase_range = range_r;
  assign irq = irq_r;
endmodule

// ---- design/flash_erase_map.svh ----
// Purpose: register offsets, field positions and reset values of the flash erase block control.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: definitions only.
`ifndef FLASH_ERASE_MAP_SVH
`define FLASH_ERASE_MAP_SVH

`define OFS_FLASH_CONTROL 12'h000
`define OFS_FLASH_STATUS 12'h004
`define OFS_EBS_LOW 12'h008
`define OFS_EBS_HIGH 12'h00c
`define OFS_IRQ_STATUS 12'h010
`define OFS_IRQ_MASK 12'h014

`define BIT_SWE 0
`define BIT_ESU 1
`define BIT_PSU 2
`define BIT_EV 3
`define BIT_PV 4
`define BIT_PEXEC 5
`define BIT_EEXEC 6
`define BIT_ERROR_FLAG 7

`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define BLOCK_SIZE 24'h00_1000
`define BLOCK_LAST 24'h00_0fff

`define IRQ_ERROR 0
`define IRQ_AUTOCLR 1
`define IRQ_WPCHG 2
`define IRQ_W 3

`endif

// ---- design/flash_erase_pkg.sv ----
// Purpose: types shared by the flash erase block control.
// Assumes: map header supplies the numbers.
// Notes: none.
`include "flash_erase_map.svh"
package flash_erase_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic sel_valid;
    logic [23:0] start_addr;
    logic [23:0] end_addr;
  } erase_range_s;
endpackage

// ---- design/erase_range_decode.sv ----
// Purpose: turns a one-hot erase block selection into an address range.
// Assumes: at most one bit set; zero or several give no valid range.
// Notes: high-register blocks follow the low ones, in order.
`timescale 1ns/1ps
`include "flash_erase_map.svh"
module erase_range_decode #(
  parameter int NBITS = 16
) (
  input wire logic [NBITS-1:0] sel,
  output flash_erase_pkg::erase_range_s range
);
  import flash_erase_pkg::*;

  function automatic logic [23:0] block_base(input logic [NBITS-1:0] s);
    logic [23:0] b;
    b = 24'h00_0000;
    for (int i = 0; i < NBITS; i++) begin
      if (s[i]) begin
        b = 24'(i) * `BLOCK_SIZE;
      end
    end
    return b;
  endfunction

  wire logic one_hot;
  wire logic [23:0] base;
  assign one_hot = (sel != '0) && ((sel & (sel - 1'b1)) == '0);
  assign base = block_base(sel);
  assign range.sel_valid = one_hot;
  assign range.start_addr = base;
  assign range.end_addr = base + `BLOCK_LAST;
endmodule

// ---- tb/flash_erase_monitor.sv ----
// Purpose: port checker for the flash erase block control.
// Assumes: registered outputs, one-cycle APB answer.
// Notes: bound to the top module.
`timescale 1ns/1ps
module flash_erase_monitor #(
  parameter int HIGH_BITS = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input flash_erase_pkg::apb_req_s apb_req,
  input flash_erase_pkg::apb_rsp_s apb_rsp,
  input wire logic flash_write_protect_input,
  input wire logic standby_req,
  input wire logic [7:0] control_bits,
  input wire logic [7:0] erase_block_select_low,
  input wire logic [HIGH_BITS-1:0] erase_block_select_high,
  input flash_erase_pkg::erase_range_s erase_range,
  input wire logic irq
);
  import flash_erase_pkg::*;
  wire logic wp = flash_write_protect_input;
  wire logic [7:0] lo = erase_block_select_low;
  wire logic [HIGH_BITS-1:0] hi = erase_block_select_high;
  wire logic [23:0] sa = erase_range.start_addr;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_wp; wp ##1 wp |-> lo == 8'h00; endproperty
  a_wp: assert property (p_wp) else $error("low select kept under protect");
  property p_swe; !control_bits[0] ##1 !control_bits[0] |-> lo == 8'h00; endproperty
  a_swe: assert property (p_swe) else $error("low select kept without enable");
  property p_multi; apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == 12'h00c
    && $countones({apb_req.pwdata[HIGH_BITS-1:0], lo}) > 1 |=> {hi, lo} == '0; endproperty
  a_multi: assert property (p_multi) else $error("several select bits kept");
  property p_stat; apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h004
    |-> (apb_rsp.prdata & 32'hffff_ff7f) == '0; endproperty
  a_stat: assert property (p_stat) else $error("status spare bits nonzero");
  property p_range; $onehot(lo) && hi == '0 |=> erase_range.sel_valid && sa[11:0] == '0
    && $past(lo) == 8'h01 << sa[14:12] && sa[23:15] == '0 && erase_range.end_addr == sa + 24'h000fff; endproperty
  a_range: assert property (p_range) else $error("erase range wrong");
  property p_stby; standby_req |=> control_bits == 8'h00 && lo == 8'h00 && hi == '0; endproperty
  a_stby: assert property (p_stby) else $error("standby left registers set");
  property p_rst; disable iff (1'b0) reset |=> control_bits == 8'h00 && !irq && !apb_rsp.pready; endproperty
  a_rst: assert property (p_rst) else $error("reset left outputs set");
  property p_ans; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer in access cycle");
  c_irq: cover property ($rose(irq));
  c_multi: cover property (apb_req.psel && apb_req.pwrite && apb_req.paddr == 12'h00c && lo != 8'h00);
  c_err: cover property (apb_rsp.pslverr);
endmodule
bind flash_erase_block_control flash_erase_monitor #(.HIGH_BITS(HIGH_BITS)) u_flash_erase_monitor (.mclk(mclk),
  .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .flash_write_protect_input(flash_write_protect_input),
  .standby_req(standby_req), .control_bits(control_bits), .erase_block_select_low(erase_block_select_low),
  .erase_block_select_high(erase_block_select_high), .erase_range(erase_range), .irq(irq));

// ---- tb/flash_erase_block_control_tb.sv ----
// Purpose: directed bench for the flash erase block control.
// Assumes: one-cycle APB answer.
// Notes: none.
`timescale 1ns/1ps
module flash_erase_block_control_tb;
  import flash_erase_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wp = 1'b0;
  logic ev = 1'b0;
  logic sb = 1'b0;
  logic err;
  logic irq;
  logic [7:0] lo;
  logic [7:0] ctl;
  logic [7:0] hi;
  logic [31:0] q;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  erase_range_s rng;
  int fail_count = 0;
  int checks = 0;
  flash_erase_block_control u_flash_erase_block_control (.mclk(mclk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .flash_write_protect_input(wp), .error_protect_event(ev), .standby_req(sb), .control_bits(ctl),
    .erase_block_select_low(lo), .erase_block_select_high(hi), .erase_range(rng), .irq(irq));
  initial forever #2 mclk = ~mclk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Holds the request until pready is seen at a rising edge, then releases at that edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        tally_and_finish;
      end
      @(posedge mclk);
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("read data", e, q);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    // Write protect low at release counts as a change
    for (int i = 0; i < 6; i++)
      rd(12'(4 * i), i == 4 ? 32'h4 : 32'h0);
    xfer(1'b1, 12'h008, 32'h1);
    rd(12'h008, 32'h0);
    xfer(1'b1, 12'h000, 32'h1);
    chk("control port", 32'h1, {24'h0, ctl});
    for (int n = 0; n < 8; n++) begin
      xfer(1'b1, 12'h008, 32'h1 << n);
      chk("range start", 32'h1000 * n, {8'h00, rng.start_addr});
      chk("low port", 32'h1 << n, {24'h0, lo});
      chk("range end", 32'h1000 * n + 32'hfff, {8'h00, rng.end_addr});
    end
    xfer(1'b1, 12'h00c, 32'h1);
    chk("high port", 32'h0, {24'h0, hi});
    rd(12'h008, 32'h0);
    rd(12'h00c, 32'h0);
    chk("range valid", 32'h0, {31'h0, rng.sel_valid});
    chk("masked irq", 32'h0, {31'h0, irq});
    rd(12'h010, 32'h2);
    $display("erase select done");
    xfer(1'b1, 12'h008, 32'h4);
    @(posedge mclk);
    wp <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("low port", 32'h0, {24'h0, lo});
    rd(12'h010, 32'h4);
    xfer(1'b1, 12'h000, 32'h0);
    @(posedge mclk);
    wp <= 1'b0;
    xfer(1'b1, 12'h014, 32'h1);
    rd(12'h010, 32'h4);
    @(posedge mclk);
    ev <= 1'b1;
    @(posedge mclk);
    ev <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h004, 32'h80);
    rd(12'h010, 32'h1);
    @(negedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge mclk);
    sb <= 1'b1;
    @(posedge mclk);
    sb <= 1'b0;
    rd(12'h004, 32'h0);
    rd(12'h014, 32'h1);
    xfer(1'b0, 12'h040, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("interrupt and standby done");
    tally_and_finish;
  end
endmodule
